// ===== rtl/wsepr_pkg.sv
package wsepr_pkg;
  // Register word offsets on the device's own interface
  localparam logic [7:0] OFS_HW_CONFIG = 8'h74;
  localparam logic [7:0] OFS_BYTE_TEST = 8'h64;
  localparam logic [7:0] OFS_POWER_CTRL = 8'h84;
  // Controller-side register offsets
  localparam logic [3:0] OFS_CTL_CMD = 4'h0;
  localparam logic [3:0] OFS_CTL_WDATA = 4'h1;
  localparam logic [3:0] OFS_CTL_STAT = 4'h2;
  localparam logic [3:0] OFS_CTL_RDATA = 4'h3;
  // Field positions of the power control register
  localparam int BIT_READY = 0;
  localparam int BIT_PIN_EN = 1;
  localparam int BIT_POLARITY = 2;
  localparam int BIT_PULSE_SEL = 3;
  localparam int BIT_CAUSE_LO = 4;
  localparam int BIT_DRV_TYPE = 6;
  localparam int BIT_ENERGY_DETECT_ENABLE = 8;
  localparam int BIT_WF_EN = 9;
  localparam int BIT_STATE_LO = 12;
  // Cause and state encodings, reset values
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_ENERGY = 2'h1;
  localparam logic [1:0] CAUSE_FRAME = 2'h2;
  localparam logic [1:0] STATE_FULL = 2'h0;
  localparam logic [1:0] STATE_FRAME = 2'h1;
  localparam logic [1:0] STATE_ENERGY = 2'h2;
  localparam logic [31:0] HW_CONFIG_RESET = 32'h0000_0000;
  // Timing
  localparam int CLK_HZ = 125_000_000;
  localparam int PULSE_MS = 50;
  localparam int PULSE_CYCLES = (CLK_HZ / 1000) * PULSE_MS;
  localparam int SETTLE_CYCLES = 16;
endpackage

// ===== rtl/wsepr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface wsepr_if;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  modport device (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// ===== rtl/wsepr_device.sv
// What this block does
// - Two-bit wake cause: none, energy, frame, multiple.
// - Cause bits clear by writing one only.
// - Cause clear works only in full power, ready.
// - Cause bit stays while its source is set and its detect enable is on.
// - Pulse select one: one 50 ms pulse.
// - Pulse select zero: event output held active.
// - Clearing a cause bit, or both enables, deactivates event output.
// - Polarity one active high, zero active low.
// - Open-drain ignores polarity, always active low.
// - Pin driven only while pin enable set.
// - Interrupt independent of pin enable.
// - Read-only ready bit after stabilizing.
// - Power control register readable in every mode.
// - Host avoids other addresses while not ready.
// - Only config and power control readable unready.
// - Host polls ready before every device access.
// - Power state 00 full, 01 frame, 10 energy.
// - Enables route events to pin and interrupt.
// - Driver type zero open-drain, one push-pull.
`timescale 1ns/1ns
`default_nettype none
module wsepr_device #(
  parameter int PULSE_LEN = wsepr_pkg::PULSE_CYCLES,
  parameter int SETTLE_LEN = wsepr_pkg::SETTLE_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Register interface
  wsepr_if.device bus,
  // Event sources
  input wire logic i_energy_event,
  input wire logic i_frame_event,
  // Event pin, interrupt and power state
  output logic o_event_pin_out,
  output logic o_event_pin_oe,
  output logic o_power_event_irq,
  output logic [1:0] o_power_state
);
  initial begin
    if (PULSE_LEN < 1) begin
      $error("wsepr_device: pulse length must be at least one cycle");
    end
    if (SETTLE_LEN < 1 || SETTLE_LEN > 65536) begin
      $error("wsepr_device: settle length must fit the 16-bit counter");
    end
  end

  // Strobe aimed at one register offset
  function automatic logic addr_hit(input logic strobe, input logic [7:0] a,
      input logic [7:0] ofs);
    return strobe && (a == ofs);
  endfunction

  // Level put on the pin for a given activity, driver type and polarity
  function automatic logic pin_level(input logic act, input logic push_pull,
      input logic act_high);
    if (!push_pull) begin
      return 1'b0;
    end
    return act_high ? act : !act;
  endfunction

  logic [1:0] state_r;
  logic ready_r;
  logic [15:0] settle_r;
  logic [1:0] cause_r;
  logic pin_en_r, pol_r, pulse_sel_r, drv_r, energy_detect_enable_r, wf_en_r;
  logic [31:0] pulse_cnt_r;
  logic active_r;
  logic [31:0] rdata_r;
  logic ctrl_wr, bt_wr, ed_hit, wf_hit, clr_ed, clr_wf;
  logic pc_rd, cfg_rd, pin_act;

  ////////////////////////////////////////////////////////////////
  assign ctrl_wr = addr_hit(bus.wr, bus.addr, wsepr_pkg::OFS_POWER_CTRL);
  assign bt_wr = addr_hit(bus.wr, bus.addr, wsepr_pkg::OFS_BYTE_TEST);
  assign pc_rd = addr_hit(bus.rd, bus.addr, wsepr_pkg::OFS_POWER_CTRL);
  assign cfg_rd = addr_hit(bus.rd, bus.addr, wsepr_pkg::OFS_HW_CONFIG);
  // Shown while active and, in pulse mode, inside the pulse window
  assign pin_act = active_r && (!pulse_sel_r || pulse_cnt_r < 32'(PULSE_LEN));
  assign ed_hit = i_energy_event && energy_detect_enable_r;
  assign wf_hit = i_frame_event && wf_en_r;
  // Clear honoured only in full power with ready set
  assign clr_ed = ctrl_wr && bus.wdata[wsepr_pkg::BIT_CAUSE_LO] && ready_r
    && (state_r == wsepr_pkg::STATE_FULL);
  assign clr_wf = ctrl_wr && bus.wdata[wsepr_pkg::BIT_CAUSE_LO + 1] && ready_r
    && (state_r == wsepr_pkg::STATE_FULL);

  ////////////////////////////////////////////////////////////////
  // Power state and ready
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r <= wsepr_pkg::STATE_FULL;
      ready_r <= 1'b0;
      settle_r <= '0;
    end else if (i_clk_en) begin
      if (state_r != wsepr_pkg::STATE_FULL && bt_wr) begin
        state_r <= wsepr_pkg::STATE_FULL;
        ready_r <= 1'b0;
        settle_r <= '0;
      end else if (ctrl_wr && ready_r
          && bus.wdata[wsepr_pkg::BIT_STATE_LO +: 2] != 2'h3) begin
        state_r <= bus.wdata[wsepr_pkg::BIT_STATE_LO +: 2];
        if (bus.wdata[wsepr_pkg::BIT_STATE_LO +: 2] != wsepr_pkg::STATE_FULL) begin
          ready_r <= 1'b0;
        end
      end else if (state_r == wsepr_pkg::STATE_FULL && !ready_r) begin
        if (32'(settle_r) >= SETTLE_LEN - 1) begin
          ready_r <= 1'b1;
        end else begin
          settle_r <= settle_r + 16'h0001;
        end
      end
    end
  end

  // Configuration bits
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pin_en_r <= 1'b0;
      pol_r <= 1'b0;
      pulse_sel_r <= 1'b0;
      drv_r <= 1'b0;
      energy_detect_enable_r <= 1'b0;
      wf_en_r <= 1'b0;
    end else if (i_clk_en && ctrl_wr && ready_r) begin
      pin_en_r <= bus.wdata[wsepr_pkg::BIT_PIN_EN];
      pol_r <= bus.wdata[wsepr_pkg::BIT_POLARITY];
      pulse_sel_r <= bus.wdata[wsepr_pkg::BIT_PULSE_SEL];
      drv_r <= bus.wdata[wsepr_pkg::BIT_DRV_TYPE];
      energy_detect_enable_r <= bus.wdata[wsepr_pkg::BIT_ENERGY_DETECT_ENABLE];
      wf_en_r <= bus.wdata[wsepr_pkg::BIT_WF_EN];
    end
  end

  // Wake cause; a live source wins over a clear
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cause_r <= wsepr_pkg::CAUSE_NONE;
    end else if (i_clk_en) begin
      cause_r[0] <= ed_hit | (cause_r[0] & ~clr_ed);
      cause_r[1] <= wf_hit | (cause_r[1] & ~clr_wf);
    end
  end

  // Event activity: pulse or level
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      active_r <= 1'b0;
      pulse_cnt_r <= '0;
    end else if (i_clk_en) begin
      if (ed_hit || wf_hit) begin
        if (!active_r) begin
          active_r <= 1'b1;
          pulse_cnt_r <= '0;
        end else if (pulse_sel_r && pulse_cnt_r < 32'(PULSE_LEN)) begin
          pulse_cnt_r <= pulse_cnt_r + 32'h1;
        end
      end else if ((clr_ed || clr_wf) || !(energy_detect_enable_r || wf_en_r)) begin
        active_r <= 1'b0;
      end else if (active_r && pulse_sel_r && pulse_cnt_r < 32'(PULSE_LEN)) begin
        pulse_cnt_r <= pulse_cnt_r + 32'h1;
      end
    end
  end

  // Pin, interrupt and read data
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_event_pin_out <= 1'b0;
      o_event_pin_oe <= 1'b0;
      o_power_event_irq <= 1'b0;
      o_power_state <= wsepr_pkg::STATE_FULL;
      rdata_r <= '0;
    end else if (i_clk_en) begin
      o_power_event_irq <= active_r;
      o_power_state <= state_r;
      o_event_pin_out <= pin_level(pin_act, drv_r, pol_r);
      if (!drv_r) begin
        o_event_pin_oe <= pin_en_r && pin_act;
      end else begin
        o_event_pin_oe <= pin_en_r;
      end
      rdata_r <= '0;
      if (pc_rd) begin
        rdata_r[wsepr_pkg::BIT_READY] <= ready_r;
        rdata_r[wsepr_pkg::BIT_PIN_EN] <= pin_en_r;
        rdata_r[wsepr_pkg::BIT_POLARITY] <= pol_r;
        rdata_r[wsepr_pkg::BIT_PULSE_SEL] <= pulse_sel_r;
        rdata_r[wsepr_pkg::BIT_CAUSE_LO +: 2] <= cause_r;
        rdata_r[wsepr_pkg::BIT_DRV_TYPE] <= drv_r;
        rdata_r[wsepr_pkg::BIT_ENERGY_DETECT_ENABLE] <= energy_detect_enable_r;
        rdata_r[wsepr_pkg::BIT_WF_EN] <= wf_en_r;
        rdata_r[wsepr_pkg::BIT_STATE_LO +: 2] <= state_r;
      end else if (cfg_rd) begin
        rdata_r <= wsepr_pkg::HW_CONFIG_RESET;
      end
    end
  end

  assign bus.rdata = rdata_r;
endmodule
`default_nettype wire

// ===== rtl/wsepr_host.sv
`timescale 1ns/1ns
`default_nettype none
module wsepr_host (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // Software port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Device side
  wsepr_if.host bus
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_POLL = 6'b000010,
    ST_WAIT = 6'b000100,
    ST_GO = 6'b001000,
    ST_RD_GAP = 6'b010000,
    ST_RD_TAKE = 6'b100000
  } wsepr_state_e;

  wsepr_state_e st_r;
  logic [7:0] cmd_addr_r;
  logic cmd_wr_r, cmd_busy_r, ready_seen_r;
  logic [31:0] cmd_wdata_r, result_r;
  logic [7:0] b_addr_r;
  logic [31:0] b_wdata_r;
  logic b_wr_r, b_rd_r;
  logic safe;

  ////////////////////////////////////////////////////////////////
  // Unready: only power control and config, or a wake write
  assign safe = ready_seen_r || cmd_addr_r == wsepr_pkg::OFS_POWER_CTRL
    || (!cmd_wr_r && cmd_addr_r == wsepr_pkg::OFS_HW_CONFIG)
    || (cmd_wr_r && cmd_addr_r == wsepr_pkg::OFS_BYTE_TEST);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_r <= ST_IDLE;
      cmd_addr_r <= 8'h00;
      cmd_wdata_r <= '0;
      cmd_wr_r <= 1'b0;
      cmd_busy_r <= 1'b0;
      ready_seen_r <= 1'b0;
      result_r <= '0;
      b_addr_r <= 8'h00;
      b_wdata_r <= '0;
      b_wr_r <= 1'b0;
      b_rd_r <= 1'b0;
      o_rdata <= '0;
    end else if (i_clk_en) begin
      b_wr_r <= 1'b0;
      b_rd_r <= 1'b0;
      if (i_wr && i_addr == wsepr_pkg::OFS_CTL_CMD && !cmd_busy_r) begin
        cmd_addr_r <= i_wdata[7:0];
        cmd_wr_r <= i_wdata[8];
        cmd_busy_r <= 1'b1;
      end else if (i_wr && i_addr == wsepr_pkg::OFS_CTL_WDATA) begin
        cmd_wdata_r <= i_wdata;
      end
      o_rdata <= '0;
      if (i_rd && i_addr == wsepr_pkg::OFS_CTL_STAT) begin
        o_rdata <= {30'h0, ready_seen_r, cmd_busy_r};
      end else if (i_rd && i_addr == wsepr_pkg::OFS_CTL_RDATA) begin
        o_rdata <= result_r;
      end
      case (st_r)
        ST_IDLE: begin
          if (cmd_busy_r) begin
            b_addr_r <= wsepr_pkg::OFS_POWER_CTRL;
            b_rd_r <= 1'b1;
            st_r <= ST_POLL;
          end
        end
        ST_POLL: begin
          st_r <= ST_WAIT;
        end
        ST_WAIT: begin
          ready_seen_r <= bus.rdata[wsepr_pkg::BIT_READY];
          st_r <= ST_GO;
        end
        ST_GO: begin
          if (safe) begin
            b_addr_r <= cmd_addr_r;
            b_wdata_r <= cmd_wdata_r;
            b_wr_r <= cmd_wr_r;
            b_rd_r <= !cmd_wr_r;
          end
          if (safe && !cmd_wr_r) begin
            st_r <= ST_RD_GAP;
          end else begin
            // Writes finish here; a refused access is dropped
            cmd_busy_r <= 1'b0;
            st_r <= ST_IDLE;
          end
        end
        ST_RD_GAP: begin
          st_r <= ST_RD_TAKE;
        end
        ST_RD_TAKE: begin
          // Read data stand only in the cycle after the strobe
          result_r <= bus.rdata;
          cmd_busy_r <= 1'b0;
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign bus.addr = b_addr_r;
  assign bus.wdata = b_wdata_r;
  assign bus.wr = b_wr_r;
  assign bus.rd = b_rd_r;
endmodule
`default_nettype wire

// ===== verif/wsepr_chk.sv
`timescale 1ns/1ns
`default_nettype none
module wsepr_chk (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Interface signals
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata
);
  localparam logic [7:0] PC = wsepr_pkg::OFS_POWER_CTRL;
  logic rdy_r;
  logic pc_rd_r;
  logic seen_r;
  wire pc_rd = rd && addr == PC;
  // Freshest ready value the host can know of
  wire rdy = pc_rd_r ? rdata[0] : rdy_r;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdy_r <= 1'b0;
      pc_rd_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      pc_rd_r <= pc_rd;
      seen_r <= seen_r | rd | wr;
      if (pc_rd_r) begin
        rdy_r <= rdata[0];
      end else if (wr && addr == PC && wdata[13:12] != 2'h0) begin
        rdy_r <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  a_poll_first: assert property ((rd || wr) && !seen_r |-> rd && addr == PC)
    else $error("first access is not a ready poll");
  a_wr_unready: assert property (wr && !rdy |-> addr == PC || addr == 8'h64)
    else $error("write while not ready");
  a_rd_unready: assert property (rd && !rdy |-> addr == PC || addr == 8'h74)
    else $error("read while not ready");
  a_hwcfg_read: assert property (rd && addr == 8'h74 |=> rdata == 32'h0)
    else $error("config read wrong");
  a_ready_full: assert property (pc_rd |=> !rdata[0] || rdata[13:12] == 2'h0)
    else $error("ready outside full power");
  a_state_legal: assert property (pc_rd |=> rdata[13:12] != 2'h3)
    else $error("reserved state seen");
  a_resv_zero: assert property (pc_rd |=> rdata[31:14] == 18'h0 && !rdata[11] && !rdata[7])
    else $error("reserved bits set");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read slot");
  c_ready_poll: cover property (pc_rd ##1 rdata[0]);
  c_wake_write: cover property (wr && addr == 8'h64);
  c_multi_cause: cover property (pc_rd ##1 rdata[5:4] == 2'h3);
endmodule
`default_nettype wire

// ===== verif/wake_status_event_pin_ready_tb.sv
`timescale 1ns/1ns
`default_nettype none
module wake_status_event_pin_ready_tb;
  localparam int PL = 20;
  localparam logic [7:0] PC = wsepr_pkg::OFS_POWER_CTRL;
  logic clk, rst, s_wr, s_rd, ev_e, ev_f, pin, oe, irq, pol;
  logic [3:0] s_addr;
  logic [31:0] s_wdata, s_rdata, rv, cfg;
  logic [1:0] pst;
  int err_total = 0;
  int total_checks = 0;
  wsepr_if bus_if ();
  wsepr_host wsepr_host_inst (.i_sys_clk(clk), .i_reset(rst), .i_clk_en(1'b1),
    .i_addr(s_addr), .i_wdata(s_wdata), .i_wr(s_wr), .i_rd(s_rd), .o_rdata(s_rdata),
    .bus(bus_if));
  wsepr_device #(.PULSE_LEN(PL), .SETTLE_LEN(16)) wsepr_device_inst (.i_sys_clk(clk),
    .i_reset(rst), .i_clk_en(1'b1), .bus(bus_if), .i_energy_event(ev_e),
    .i_frame_event(ev_f), .o_event_pin_out(pin), .o_event_pin_oe(oe),
    .o_power_event_irq(irq), .o_power_state(pst));
  wsepr_chk wsepr_chk_inst (.i_sys_clk(clk), .i_reset(rst), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata));
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One software port cycle; read data land in rv
  task automatic sw(input logic [3:0] a, input logic [31:0] d, input logic w);
    @(posedge clk);
    s_addr <= a;
    s_wdata <= d;
    s_wr <= w;
    s_rd <= !w;
    @(posedge clk);
    s_wr <= 1'b0;
    s_rd <= 1'b0;
    #1 rv = s_rdata;
  endtask
  // Device access through the controller, bounded wait on busy
  task automatic dev(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    sw(wsepr_pkg::OFS_CTL_WDATA, d, 1'b1);
    sw(wsepr_pkg::OFS_CTL_CMD, {23'h0, w, a}, 1'b1);
    rv = 32'h1;
    for (n = 0; n < 200 && rv[0] !== 1'b0; n++) begin
      sw(wsepr_pkg::OFS_CTL_STAT, 32'h0, 1'b0);
    end
    if (rv[0] !== 1'b0) begin
      err_total++;
      close_out();
    end
    sw(wsepr_pkg::OFS_CTL_RDATA, 32'h0, 1'b0);
  endtask
  task automatic evt(input logic e, input logic f, input int hold);
    @(posedge clk);
    ev_e <= e;
    ev_f <= f;
    repeat (hold) @(posedge clk);
    ev_e <= 1'b0;
    ev_f <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst, s_wr, s_rd, ev_e, ev_f, s_addr, s_wdata} = {1'b1, 40'h0};
    void'($urandom(33758));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    dev(PC, 32'h0, 1'b0);
    chk("ready", rv, 32'h1);
    dev(PC, 32'h1, 1'b1);
    dev(PC, 32'h0, 1'b0);
    chk("ready ro", rv, 32'h1);
    dev(8'h74, 32'h0, 1'b0);
    chk("hwcfg", rv, wsepr_pkg::HW_CONFIG_RESET);
    for (int k = 0; k < 2; k++) begin
      pol = k[0] ^ $urandom_range(1);
      cfg = 32'h142 | {29'h0, pol, 2'h0};
      dev(PC, cfg, 1'b1);
      evt(1'b1, 1'b0, 1 + $urandom_range(4));
      repeat (30) @(posedge clk);
      #1;
      chk("level pin", {oe, pin, irq}, {1'b1, pol, 1'b1});
      dev(PC, cfg, 1'b1);
      dev(PC, 32'h0, 1'b0);
      chk("cause kept", rv, cfg | 32'h11);
      @(posedge clk);
      ev_e <= 1'b1;
      dev(PC, cfg | 32'h30, 1'b1);
      dev(PC, 32'h0, 1'b0);
      chk("source held", rv[5:4], 32'h1);
      ev_e <= 1'b0;
      dev(PC, cfg | 32'h10, 1'b1);
      chk("released", {oe, pin, irq}, {1'b1, !pol, 1'b0});
    end
    dev(PC, 32'h30E, 1'b1);
    evt(1'b1, 1'b1, 1);
    chk("od pulse", {oe, pin}, 32'h2);
    repeat (PL + 5) @(posedge clk);
    #1;
    chk("pulse end", oe, 32'h0);
    dev(PC, 32'h330, 1'b1);
    for (int i = 1; i < 4; i++) begin
      dev(PC, 32'h300, 1'b1);
      evt(i[0], i[1], 2);
      chk("irq no pin", {oe, irq}, 32'h1);
      dev(PC, 32'h0, 1'b0);
      chk("cause", rv[5:4], i);
      dev(PC, 32'h330, 1'b1);
    end
    dev(PC, 32'h100, 1'b1);
    evt(1'b1, 1'b0, 2);
    dev(PC, 32'h1100, 1'b1);
    dev(PC, 32'h0, 1'b0);
    chk("sleep", rv, 32'h1110);
    chk("state pin", pst, wsepr_pkg::STATE_FRAME);
    dev(PC, 32'h1130, 1'b1);
    dev(8'h7C, 32'h0, 1'b0);
    dev(8'h64, $urandom, 1'b1);
    repeat (20) @(posedge clk);
    dev(PC, 32'h0, 1'b0);
    chk("awake", rv, 32'h111);
    dev(PC, 32'h3130, 1'b1);
    dev(PC, 32'h0, 1'b0);
    chk("state cause", {rv[13:12], rv[5:4]}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
